// >>> bench/tb_buck_voltage_register_bank.sv
/*
  Self-checking bench for the converter voltage register bank: an integer
  model of the four registers is compared with every output and read.
  Assumes buck_pkg and the design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_buck_voltage_register_bank;
  import buck_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        rst_n;
  reg_req_s    req;
  logic [7:0]  rd_data;
  logic        fuse_reload;
  fuse_s       fuse;
  logic        forced_off;
  logic [1:0]  conv3_range;
  logic [5:0]  conv3_ceiling;
  logic        conv3_lock;
  logic        conv4_enable;
  logic        conv4_low_power;
  logic        conv4_set_choice;
  logic        conv4_lock;
  logic [15:0] op_mv;
  logic [15:0] alt_mv;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] f;
  logic [7:0]  d;
  int          err_count;
  int          comparisons;
  int          m [4];

  buck_voltage_register_bank buck_voltage_register_bank_i (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
    .fuse_reload(fuse_reload), .fuse(fuse), .forced_off(forced_off),
    .conv3_range(conv3_range), .conv3_ceiling(conv3_ceiling),
    .conv3_lock(conv3_lock), .conv4_enable(conv4_enable),
    .conv4_low_power(conv4_low_power), .conv4_set_choice(conv4_set_choice),
    .conv4_lock(conv4_lock), .conv4_op_tenth_mv(op_mv),
    .conv4_alt_tenth_mv(alt_mv)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Model
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int volt(int rng, int c);
    case (rng)
      0: return 5000 + 125 * c;
      1: return 7000 + 125 * c;
      2: return 5000 + 250 * c;
      default: return (c == 63) ? 38000 : 5000 + 500 * c;
    endcase
  endfunction

  function automatic int lk(int v);
    return (v % 64 != 63) && (v % 64 != 0);
  endfunction

  function automatic int clamp(int c, int ceil);
    return (c > ceil) ? ceil : c;
  endfunction

  task automatic mwrite(logic [7:0] a, logic [7:0] v);
    case (a)
      8'h0C: if (!lk(m[0])) m[0] = v;
      8'h0D: m[1] = (v & 8'h40) | clamp(v % 64, m[3] % 64);
      8'h0E: m[2] = (v & 8'hC0) | clamp(v % 64, m[3] % 64);
      8'h0F: if (!lk(m[3])) m[3] = v;
      default: ;
    endcase
  endtask

  // Fuse set-choice and low-power bits never load as ones
  task automatic load(logic [31:0] v);
    m[0] = v[31:24];
    m[1] = v[23:16] & 8'h3F;
    m[2] = v[15:8] & 8'hBF;
    m[3] = v[7:0];
  endtask

  // ----------------------------------------------------------------
  // Drivers and comparisons
  // ----------------------------------------------------------------
  task automatic chk(logic [15:0] got, int exp);
    comparisons++;
    if (got !== exp[15:0]) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp[15:0]);
    end
  endtask

  task automatic check_all();
    @(posedge core_clk);
    #1;
    chk(conv3_range, m[0] / 64);
    chk(conv3_ceiling, m[0] % 64);
    chk(conv3_lock, lk(m[0]));
    chk(conv4_lock, lk(m[3]));
    chk(conv4_enable, (m[2] / 128) & !forced_off);
    chk(conv4_low_power, (m[2] / 64) % 2);
    chk(conv4_set_choice, (m[1] / 64) % 2);
    chk(op_mv, volt(m[3] / 64, m[1] % 64));
    chk(alt_mv, volt(m[3] / 64, m[2] % 64));
  endtask

  // One write or read; strobe dropped at the edge that takes it
  task automatic access(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge core_clk);
    req <= '{wr_en: w, rd_en: !w, addr: a, wdata: v};
    @(posedge core_clk);
    req <= '0;
    #1;
    if (w) mwrite(a, v);
    else chk(rd_data, (a >= 8'h0C && a <= 8'h0F) ? m[a - 12] : 0);
  endtask

  task automatic reload(logic [31:0] v);
    @(posedge core_clk);
    fuse <= v;
    fuse_reload <= 1'b1;
    @(posedge core_clk);
    fuse_reload <= 1'b0;
    repeat (2) @(posedge core_clk);
    load(v);
    check_all();
  endtask

  task automatic do_reset(logic [31:0] v);
    @(posedge core_clk);
    fuse <= v;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    load(v);
    check_all();
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h0000_0038;
    err_count = 0;
    comparisons = 0;
    req = '0;
    fuse_reload = 1'b0;
    forced_off = 1'b0;
    rst_n = 1'b0;
    fuse = '0;
    // Locked third limit from fuse, open fourth limit
    do_reset(32'h4AD2_C53F);
    for (int a = 8'h0B; a <= 8'h10; a++) access(1'b0, 8'(a), 8'h00);
    access(1'b1, 8'h0C, 8'hFF);
    access(1'b0, 8'h0C, 8'h00);
    $display("test defaults done");
    for (int rg = 0; rg < 4; rg++) begin
      @(posedge core_clk);
      forced_off <= (rg == 2);
      access(1'b1, 8'h0F, 8'(rg * 64 + 63));
      foreach (m[i]) begin
        d = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : (i == 2) ? 8'h3E : 8'h3F;
        access(1'b1, 8'h0D, d | 8'h40);
        access(1'b1, 8'h0E, d | 8'h80);
        check_all();
      end
    end
    $display("test ranges done");
    // Ceiling 0x20 locks; later limit writes must vanish
    access(1'b1, 8'h0F, 8'h60);
    access(1'b1, 8'h0D, 8'h3F);
    access(1'b1, 8'h0F, 8'hFF);
    access(1'b1, 8'h0E, 8'hE1);
    access(1'b0, 8'h0F, 8'h00);
    access(1'b0, 8'h0D, 8'h00);
    check_all();
    $display("test lock done");
    for (int k = 0; k < 6; k++) begin
      f = xs();
      f[5:0] = (k % 3 == 0) ? 6'h3F : (k % 3 == 1) ? 6'h00 : f[5:0];
      // Open third limit on every other reload so its writes land
      f[29:24] = (k % 2 == 0) ? 6'h00 : f[29:24];
      reload(f);
      repeat (30) begin
        r = xs();
        d = r[15:8];
        if (r[18:16] == 3'h2) d[7] = 1'b0; // Host keeps reserved bit clear
        @(posedge core_clk);
        forced_off <= r[20];
        access(r[21], 8'h0B + 8'(r[18:16] % 6), d);
        check_all();
      end
    end
    $display("test random done");
    do_reset(xs());
    $display("test second reset done");
    final_report();
  end

  // Whole run needs under a thousand cycles
  initial begin
    #100000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire

// >>> verilog/buck_params.svh
/*
  Constants for the step-down converter voltage register bank: register
  offsets, field positions, lock codes and the voltage ladder figures.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef BUCK_PARAMS_SVH
`define BUCK_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets on the serial control port
// ----------------------------------------------------------------------
`define OFS_C3_LIMIT   8'h0C
`define OFS_C4_OP      8'h0D
`define OFS_C4_ALT     8'h0E
`define OFS_C4_LIMIT   8'h0F

// ----------------------------------------------------------------------
// Field positions and fixed values
// ----------------------------------------------------------------------
`define BIT_TOP        7
`define BIT_REGISTER_SET_CHOICE     6
`define CEIL_ALL_ONES  6'h3F
`define CEIL_ZERO      6'h00
`define RESET_BYTE     8'h00
`define READ_UNMAPPED  8'h00

// ----------------------------------------------------------------------
// Voltage ladder, in units of 0.1 mV
// ----------------------------------------------------------------------
`define V_BASE_LOW     16'h1388
`define V_BASE_HIGH    16'h1B58
`define V_STEP_FINE    16'h007D
`define V_STEP_MID     16'h00FA
`define V_STEP_COARSE  16'h01F4
`define V_TOP_WIDE     16'h9470

`endif

// >>> verilog/buck_pkg.sv
/*
  Types shared by the converter register bank and its voltage decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package buck_pkg;

  // Output range selector, encodings 00b to 11b in order
  typedef enum logic [1:0] {
    RANGE_FINE_LOW,
    RANGE_FINE_HIGH,
    RANGE_MID,
    RANGE_WIDE
  } range_e;

  typedef struct packed {
    range_e     range;
    logic [5:0] ceiling;
  } limit_s;

  typedef struct packed {
    logic       rsvd;
    logic       register_set_choice;
    logic [5:0] code;
  } op_s;

  typedef struct packed {
    logic       enable;
    logic       low_power;
    logic [5:0] code;
  } alt_s;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    limit_s c3_limit;
    op_s    c4_op;
    alt_s   c4_alt;
    limit_s c4_limit;
  } fuse_s;

  typedef enum logic {
    LOAD_FUSE,
    RUN
  } load_state_e;

endpackage

// >>> verilog/buck_voltage_register_bank.sv
/*
  Voltage registers of the third converter's limit and the fourth
  converter's operating, alternate and limit registers, with ceiling clamp,
  field lock and voltage decode. Assumes a serial control front end that
  presents one-cycle read and write strobes on core_clk, and a fuse
  controller that presents default contents and a reload pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "buck_params.svh"

// Notes on behaviour
// - Written voltage codes above the ceiling are stored as the ceiling.
// - Ceiling other than all-ones or zero locks range and ceiling until reload.
// - Limit register holds range in bits 7-6, ceiling in 5-0, fuse defaults.
// - Range 00b: 0.5 V plus 12.5 mV per code.
// - Range 01b: 0.7 V plus 12.5 mV per code.
// - Range 10b: 0.5 V plus 25 mV per code.
// - Range 11b: 0.5 V plus 50 mV per code, top code gives 3.80 V.
// - Codes are decoded with the range held in the converter's limit.
// - Power-on reset reloads all these registers from fuse memory.
// - Alternate top bit turns converter on unless forced off.
// - Operating top bit reads zero, host writes zero; bit 6 defaults zero.
module buck_voltage_register_bank (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Register access
  input  wire buck_pkg::reg_req_s req,
  output logic [7:0]             rd_data,
  // Fuse memory
  input  wire logic              fuse_reload,
  input  wire buck_pkg::fuse_s   fuse,
  // Converter control
  input  wire logic              forced_off,
  output logic [1:0]             conv3_range,
  output logic [5:0]             conv3_ceiling,
  output logic                   conv3_lock,
  output logic                   conv4_enable,
  output logic                   conv4_low_power,
  output logic                   conv4_set_choice,
  output logic                   conv4_lock,
  output logic [15:0]            conv4_op_tenth_mv,
  output logic [15:0]            conv4_alt_tenth_mv
);
  import buck_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic locked(input logic [5:0] ceiling);
    locked = (ceiling != `CEIL_ALL_ONES) && (ceiling != `CEIL_ZERO);
  endfunction

  function automatic logic [5:0] clamp(input logic [5:0] code,
                                       input logic [5:0] ceiling);
    clamp = (code > ceiling) ? ceiling : code;
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  load_state_e state_r;
  load_state_e state_nxt;
  limit_s      c3_lim_r;
  limit_s      c3_lim_nxt;
  limit_s      c4_lim_r;
  limit_s      c4_lim_nxt;
  op_s         c4_op_r;
  op_s         c4_op_nxt;
  alt_s        c4_alt_r;
  alt_s        c4_alt_nxt;
  logic [7:0]  rd_data_r;
  logic [7:0]  rd_data_nxt;
  logic        en_r;
  logic        en_nxt;
  logic [15:0] op_mv_r;
  logic [15:0] alt_mv_r;
  logic [15:0] op_mv_dec;
  logic [15:0] alt_mv_dec;
  logic        wr_ok;

  assign wr_ok = req.wr_en && (state_r == RUN);

  // --------------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    c3_lim_nxt  = c3_lim_r;
    c4_lim_nxt  = c4_lim_r;
    c4_op_nxt   = c4_op_r;
    c4_alt_nxt  = c4_alt_r;
    rd_data_nxt = rd_data_r;
    en_nxt      = c4_alt_r.enable && !forced_off;
    case (state_r)
      LOAD_FUSE: begin
        // Defaults come from fuses; selector and low-power bits default zero
        c3_lim_nxt = fuse.c3_limit;
        c4_lim_nxt = fuse.c4_limit;
        c4_op_nxt  = '{rsvd: 1'b0, register_set_choice: 1'b0,
                       code: fuse.c4_op.code};
        c4_alt_nxt = '{enable: fuse.c4_alt.enable, low_power: 1'b0,
                       code: fuse.c4_alt.code};
        state_nxt  = RUN;
      end
      RUN: begin
        if (fuse_reload) begin
          state_nxt = LOAD_FUSE;
        end else if (wr_ok) begin
          case (req.addr)
            `OFS_C3_LIMIT: begin
              if (!locked(c3_lim_r.ceiling)) begin
                c3_lim_nxt = limit_s'(req.wdata);
              end
            end
            `OFS_C4_LIMIT: begin
              if (!locked(c4_lim_r.ceiling)) begin
                c4_lim_nxt = limit_s'(req.wdata);
              end
            end
            `OFS_C4_OP: begin
              // Top bit is never stored, so it always reads back zero
              c4_op_nxt.rsvd                = 1'b0;
              c4_op_nxt.register_set_choice = req.wdata[`BIT_REGISTER_SET_CHOICE];
              c4_op_nxt.code = clamp(req.wdata[5:0], c4_lim_r.ceiling);
            end
            `OFS_C4_ALT: begin
              c4_alt_nxt.enable    = req.wdata[`BIT_TOP];
              c4_alt_nxt.low_power = req.wdata[`BIT_REGISTER_SET_CHOICE];
              c4_alt_nxt.code = clamp(req.wdata[5:0], c4_lim_r.ceiling);
            end
            default: begin
              c4_op_nxt = c4_op_r;
            end
          endcase
        end
      end
      default: begin
        state_nxt = LOAD_FUSE;
      end
    endcase
    if (req.rd_en) begin
      case (req.addr)
        `OFS_C3_LIMIT: rd_data_nxt = c3_lim_r;
        `OFS_C4_OP:    rd_data_nxt = {1'b0, c4_op_r[6:0]};
        `OFS_C4_ALT:   rd_data_nxt = c4_alt_r;
        `OFS_C4_LIMIT: rd_data_nxt = c4_lim_r;
        default:       rd_data_nxt = `READ_UNMAPPED;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Reset parks registers at zero and both voltages at V_BASE_LOW; fuse contents arrive one edge later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= LOAD_FUSE;
      c3_lim_r  <= limit_s'(`RESET_BYTE);
      c4_lim_r  <= limit_s'(`RESET_BYTE);
      c4_op_r   <= op_s'(`RESET_BYTE);
      c4_alt_r  <= alt_s'(`RESET_BYTE);
      rd_data_r <= `RESET_BYTE;
      en_r      <= 1'b0;
      op_mv_r   <= `V_BASE_LOW;
      alt_mv_r  <= `V_BASE_LOW;
    end else begin
      state_r   <= state_nxt;
      c3_lim_r  <= c3_lim_nxt;
      c4_lim_r  <= c4_lim_nxt;
      c4_op_r   <= c4_op_nxt;
      c4_alt_r  <= c4_alt_nxt;
      rd_data_r <= rd_data_nxt;
      en_r      <= en_nxt;
      op_mv_r   <= op_mv_dec;
      alt_mv_r  <= alt_mv_dec;
    end
  end

  // --------------------------------------------------------------------
  // Voltage decode
  // --------------------------------------------------------------------
  // Both codes follow the range now held in the limit register
  voltage_decode u_op_decode (
    .range    (c4_lim_r.range),
    .code     (c4_op_r.code),
    .tenth_mv (op_mv_dec)
  );

  voltage_decode u_alt_decode (
    .range    (c4_lim_r.range),
    .code     (c4_alt_r.code),
    .tenth_mv (alt_mv_dec)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign rd_data            = rd_data_r;
  assign conv3_range        = c3_lim_r.range;
  assign conv3_ceiling      = c3_lim_r.ceiling;
  assign conv3_lock         = locked(c3_lim_r.ceiling);
  assign conv4_lock         = locked(c4_lim_r.ceiling);
  assign conv4_enable       = en_r;
  assign conv4_low_power    = c4_alt_r.low_power;
  assign conv4_set_choice   = c4_op_r.register_set_choice;
  assign conv4_op_tenth_mv  = op_mv_r;
  assign conv4_alt_tenth_mv = alt_mv_r;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] ofs);
    wr_ok && !fuse_reload && req.addr == ofs;
  endsequence

  sequence s_steady_wide_top;
    (c4_lim_r.range == RANGE_WIDE && c4_op_r.code == `CEIL_ALL_ONES) [*2];
  endsequence

  chk_clamp_op: assert property (
    s_wr(`OFS_C4_OP) and (req.wdata[5:0] > c4_lim_r.ceiling)
    |=> c4_op_r.code == $past(c4_lim_r.ceiling))
    else $error("operating code not clamped to ceiling");

  chk_clamp_alt: assert property (
    s_wr(`OFS_C4_ALT) and (req.wdata[5:0] <= c4_lim_r.ceiling)
    |=> c4_alt_r.code == $past(req.wdata[5:0]))
    else $error("alternate code in range not stored as written");

  chk_lock_hold: assert property (
    s_wr(`OFS_C4_LIMIT) and conv4_lock |=> $stable(c4_lim_r) ##1 conv4_lock)
    else $error("locked limit register changed on write");

  chk_limit_write: assert property (
    s_wr(`OFS_C3_LIMIT) and !conv3_lock |=> c3_lim_r == $past(req.wdata))
    else $error("unlocked limit register did not take write");

  // Release edge excluded: the load happens one edge after it
  chk_fuse_load: assert property (
    rst_n && state_r == LOAD_FUSE |=> c4_lim_r == $past(fuse.c4_limit)
      && c4_op_r.register_set_choice == 1'b0 && state_r == RUN)
    else $error("fuse defaults not loaded");

  chk_enable_gate: assert property (
    c4_alt_r.enable && !forced_off |=> conv4_enable ##0 1'b1)
    else $error("converter not enabled");

  chk_enable_off: assert property (
    !c4_alt_r.enable || forced_off |=> !conv4_enable)
    else $error("converter enabled while off or forced off");

  chk_op_top_zero: assert property (
    req.rd_en && req.addr == `OFS_C4_OP |=> rd_data[`BIT_TOP] == 1'b0)
    else $error("reserved operating bit read nonzero");

  chk_wide_top: assert property (
    s_steady_wide_top |-> conv4_op_tenth_mv == `V_TOP_WIDE)
    else $error("top wide code not decoded as 3.80 V");

  // Decoded value trails the code by one edge, so the code must hold across it
  chk_fine_ladder: assert property (
    (c4_lim_r.range == RANGE_FINE_LOW) ##1
    (c4_lim_r.range == RANGE_FINE_LOW && $stable(c4_alt_r.code))
    |-> conv4_alt_tenth_mv == 16'(`V_BASE_LOW + 16'(c4_alt_r.code) * `V_STEP_FINE))
    else $error("fine range decode wrong");

endmodule

`default_nettype wire

// >>> verilog/voltage_decode.sv
/*
  Turns a six-bit voltage code and a range selector into an output voltage
  in units of 0.1 mV. Pure combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "buck_params.svh"

module voltage_decode (
  // Selection
  input  wire buck_pkg::range_e range,
  input  wire logic [5:0]       code,
  // Result
  output logic [15:0]           tenth_mv
);
  import buck_pkg::*;

  logic [15:0] base;
  logic [15:0] step;

  always_comb begin
    base     = `V_BASE_LOW;
    step     = `V_STEP_FINE;
    case (range)
      RANGE_FINE_LOW: begin
        base = `V_BASE_LOW;
        step = `V_STEP_FINE;
      end
      RANGE_FINE_HIGH: begin
        base = `V_BASE_HIGH;
        step = `V_STEP_FINE;
      end
      RANGE_MID: begin
        base = `V_BASE_LOW;
        step = `V_STEP_MID;
      end
      RANGE_WIDE: begin
        base = `V_BASE_LOW;
        step = `V_STEP_COARSE;
      end
      default: begin
        base = `V_BASE_LOW;
        step = `V_STEP_FINE;
      end
    endcase
    tenth_mv = 16'(base + 16'(code) * step);
    // Top code of the wide range breaks the linear ladder
    if (range == RANGE_WIDE && code == `CEIL_ALL_ONES) begin
      tenth_mv = `V_TOP_WIDE;
    end
  end

endmodule

`default_nettype wire
